// ===== design/smon_spi_port.sv
// Host serial slave port of the stack monitor, full and half duplex.
// Assumes host SPI mode 0, sclk idle low, cs_n setup over 100 ns.
`include "smon_params.svh"
`timescale 1ns/1ps
`default_nettype none

module smon_spi_port (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             sclk,
    input  wire logic             cs_n,
    input  wire logic             din,
    input  wire logic             daisy_cfg,
    input  wire logic             rd_done,
    input  wire smon_pkg::rd_rsp_t rd_rsp,
    input  wire logic             rsp_valid,
    input  wire logic [7:0]       rsp_byte,
    output logic                  dout,
    output logic                  dout_oe,
    output logic                  data_ready_n,
    output logic                  cmd_valid,
    output smon_pkg::sa_cmd_t     cmd,
    output logic                  dc_valid,
    output smon_pkg::dc_cmd_t     dc_cmd,
    output logic                  rsp_ready
);
    import smon_pkg::*;

    localparam logic [12:0] TO_CYC = 13'(`CS_TIMEOUT_CYCLES);
    localparam logic [3:0]  NBITS  = 4'(`BYTE_BITS);

    // Reference domain state
    logic [7:0]  tx_hold;
    logic [7:0]  next_tx_hold;

    // Link domain, clocked by the host serial clock
    logic [2:0]  bit_cnt;
    logic [2:0]  next_bit_cnt;
    logic [7:0]  rx_shift;
    logic [7:0]  next_rx_shift;
    logic        edge_tog;
    logic        next_edge_tog;
    logic        tx_bit;
    logic        next_tx_bit;
    logic        shifted;

    always_comb begin
        next_bit_cnt  = bit_cnt + 3'h1;
        next_rx_shift = {rx_shift[6:0], din};
        next_edge_tog = ~edge_tog;
        next_tx_bit   = tx_hold[3'h7 - bit_cnt];
    end

    // Frame counter ends with the frame itself: sclk stops outside it
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt <= 3'h0;
        end else begin
            bit_cnt <= next_bit_cnt;
        end
    end

    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            rx_shift <= 8'h00;
            edge_tog <= 1'b0;
        end else begin
            rx_shift <= next_rx_shift;
            edge_tog <= next_edge_tog;
        end
    end

    // Later bits leave on falling edges; the first is tx_hold[7]
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            tx_bit  <= 1'b0;
            shifted <= 1'b0;
        end else begin
            tx_bit  <= next_tx_bit;
            shifted <= 1'b1;
        end
    end

    // First bit must stand before any sclk edge, hence the flop select
    assign dout = shifted ? tx_bit : tx_hold[7];

    // Synchronisers
    logic cs_s1, cs_s2, cs_d;
    logic tog_s1, tog_s2, tog_d;
    logic cfg_s1, cfg_s2;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cs_s1  <= 1'b1;
            cs_s2  <= 1'b1;
            cs_d   <= 1'b1;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_d  <= 1'b0;
            cfg_s1 <= 1'b0;
            cfg_s2 <= 1'b0;
        end else begin
            cs_s1  <= cs_n;
            cs_s2  <= cs_s1;
            cs_d   <= cs_s2;
            tog_s1 <= edge_tog;
            tog_s2 <= tog_s1;
            tog_d  <= tog_s2;
            cfg_s1 <= daisy_cfg;
            cfg_s2 <= cfg_s1;
        end
    end

    function automatic logic page_known(input logic [2:0] pg);
        page_known = (pg >= `PAGE_FIRST) && (pg <= `PAGE_LAST);
    endfunction : page_known

    // Bytes arrive top first: a read sits in the low 16 bits
    function automatic sa_cmd_t sa_decode(input logic [23:0] w,
                                          input logic        wr);
        sa_cmd_t c;
        c = w;
        if (!wr) begin
            c.rw   = 1'b0;
            c.page = w[14:12];
            c.addr = w[11:6];
            c.data = 14'h0000;
            if (w[14:12] == `MEAS_PAGE && w[11:6] == `MEAS_ADDR) begin
                c.data = {8'h00, w[5:0]};
            end
        end
        sa_decode = c;
    endfunction : sa_decode

    // Control state
    logic        daisy, next_daisy;
    logic [1:0]  strap_cnt, next_strap_cnt;
    logic [12:0] to_cnt, next_to_cnt;
    logic [3:0]  edge_cnt, next_edge_cnt;
    logic [1:0]  byte_idx, next_byte_idx;
    logic        cur_wr, next_cur_wr;
    logic [23:0] shreg, next_shreg;
    logic        pending, next_pending;
    logic [15:0] resp, next_resp;
    logic        frame_tx, next_frame_tx;
    hd_state_t   hd_state, next_hd_state;
    logic        next_dr_n;
    logic        next_rsp_ready;
    logic        next_dout_oe;
    logic        next_cmd_valid;
    sa_cmd_t     next_cmd;
    logic        next_dc_valid;
    dc_cmd_t     next_dc_cmd;

    logic        cs_rise, cs_fall, sck_edge, timeout;
    logic        full_byte, partial, rx_ok, is_wr, last, take;
    logic [3:0]  frame_bits;
    logic [1:0]  len;
    sa_cmd_t     dec;

    always_comb begin
        cs_rise    = cs_s2 & ~cs_d;
        cs_fall    = ~cs_s2 & cs_d;
        sck_edge   = tog_s2 ^ tog_d;
        frame_bits = edge_cnt + {3'h0, sck_edge};
        full_byte  = cs_rise && (frame_bits == NBITS);
        partial    = cs_rise && !full_byte && (frame_bits != 4'h0);
        timeout    = cs_s2 && (to_cnt == TO_CYC - 13'h1);
        is_wr      = (byte_idx == 2'h0) ? rx_shift[`SA_RW_POS] : cur_wr;
        if (daisy) begin
            len = 2'(`DC_CMD_BYTES);
        end else if (is_wr) begin
            len = 2'(`SA_WRITE_BYTES);
        end else begin
            len = 2'(`SA_READ_BYTES);
        end
        last = (byte_idx == len - 2'h1);
        take = rsp_valid && rsp_ready && (hd_state == HD_IDLE);

        next_daisy     = daisy;
        next_strap_cnt = strap_cnt;
        if (strap_cnt != `STRAP_WAIT) begin
            next_daisy     = cfg_s2;
            next_strap_cnt = strap_cnt + 2'h1;
        end

        next_to_cnt = 13'h0000;
        if (cs_s2 && to_cnt != TO_CYC) begin
            next_to_cnt = to_cnt + 13'h0001;
        end

        next_edge_cnt = edge_cnt;
        if (cs_s2 && cs_d) begin
            next_edge_cnt = 4'h0;
        end else if (sck_edge && edge_cnt != 4'hf) begin
            next_edge_cnt = edge_cnt + 4'h1;
        end

        next_frame_tx = frame_tx;
        if (cs_fall) begin
            next_frame_tx = daisy && (hd_state == HD_READY);
        end
        rx_ok = full_byte && !frame_tx;

        next_byte_idx  = byte_idx;
        next_cur_wr    = cur_wr;
        next_shreg     = shreg;
        next_pending   = pending;
        next_resp      = resp;
        next_cmd_valid = 1'b0;
        next_cmd       = cmd;
        next_dc_valid  = 1'b0;
        next_dc_cmd    = dc_cmd;
        dec            = sa_decode(24'h000000, 1'b0);

        if (rx_ok) begin
            next_shreg = {shreg[15:0], rx_shift};
            if (byte_idx == 2'h0) begin
                next_cur_wr = rx_shift[`SA_RW_POS];
            end
            // Second byte of any stand-alone transaction carries the pending low byte
            if (!daisy && byte_idx == 2'h1) begin
                next_pending = 1'b0;
            end
            if (last) begin
                next_byte_idx = 2'h0;
                if (daisy) begin
                    next_dc_valid = 1'b1;
                    next_dc_cmd   = next_shreg;
                end else begin
                    dec = sa_decode(next_shreg, is_wr);
                    if (page_known(dec.page)) begin
                        next_cmd_valid = 1'b1;
                        next_cmd       = dec;
                    end else if (!is_wr) begin
                        next_resp    = `RESP_UNKNOWN;
                        next_pending = 1'b1;
                    end
                end
            end else begin
                next_byte_idx = byte_idx + 2'h1;
            end
        end else if ((partial && !frame_tx) || timeout) begin
            next_byte_idx = 2'h0;
        end

        if (timeout && !daisy) begin
            next_pending = 1'b0;
        end

        // Answer set after clears so a late answer is never lost
        if (rd_done && !daisy) begin
            next_resp    = rd_rsp.hit ? rd_rsp.data : `RESP_UNKNOWN;
            next_pending = 1'b1;
        end

        next_tx_hold = tx_hold;
        if (!daisy && cs_s2) begin
            next_tx_hold = `TX_IDLE_BYTE;
            if (pending && byte_idx == 2'h0) begin
                next_tx_hold = resp[15:8];
            end else if (pending && byte_idx == 2'h1) begin
                next_tx_hold = resp[7:0];
            end
        end

        next_hd_state = hd_state;
        next_dr_n     = data_ready_n;
        case (hd_state)
            HD_IDLE: begin
                next_dr_n = 1'b1;
                if (take) begin
                    next_tx_hold  = rsp_byte;
                    next_hd_state = HD_READY;
                end
            end
            HD_READY: begin
                if (cs_fall && !data_ready_n) begin
                    next_hd_state = HD_SEND;
                end else begin
                    next_dr_n = !cs_s2;
                end
            end
            HD_SEND: begin
                if (cs_rise) begin
                    next_dr_n     = 1'b1;
                    // A short frame keeps the byte for another try
                    next_hd_state = full_byte ? HD_IDLE : HD_READY;
                end
            end
            default: begin
                next_hd_state = HD_IDLE;
                next_dr_n     = 1'b1;
            end
        endcase
        if (!daisy) begin
            next_hd_state = HD_IDLE;
            next_dr_n     = 1'b1;
        end

        next_rsp_ready = daisy && cs_s2 && !take
                         && (next_hd_state == HD_IDLE);
        next_dout_oe   = !cs_s2 && (!daisy || next_frame_tx);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            daisy        <= 1'b0;
            strap_cnt    <= 2'h0;
            to_cnt       <= 13'h0000;
            edge_cnt     <= 4'h0;
            byte_idx     <= 2'h0;
            cur_wr       <= 1'b0;
            shreg        <= 24'h000000;
            pending      <= 1'b0;
            resp         <= 16'h0000;
            frame_tx     <= 1'b0;
            tx_hold      <= 8'h00;
            hd_state     <= HD_IDLE;
            data_ready_n <= 1'b1;
            rsp_ready    <= 1'b0;
            dout_oe      <= 1'b0;
            cmd_valid    <= 1'b0;
            cmd          <= '0;
            dc_valid     <= 1'b0;
            dc_cmd       <= '0;
        end else begin
            daisy        <= next_daisy;
            strap_cnt    <= next_strap_cnt;
            to_cnt       <= next_to_cnt;
            edge_cnt     <= next_edge_cnt;
            byte_idx     <= next_byte_idx;
            cur_wr       <= next_cur_wr;
            shreg        <= next_shreg;
            pending      <= next_pending;
            resp         <= next_resp;
            frame_tx     <= next_frame_tx;
            tx_hold      <= next_tx_hold;
            hd_state     <= next_hd_state;
            data_ready_n <= next_dr_n;
            rsp_ready    <= next_rsp_ready;
            dout_oe      <= next_dout_oe;
            cmd_valid    <= next_cmd_valid;
            cmd          <= next_cmd;
            dc_valid     <= next_dc_valid;
            dc_cmd       <= next_dc_cmd;
        end
    end

endmodule : smon_spi_port

`default_nettype wire

// ===== design/smon_params.svh
// Constants for the stack monitor host serial port.
// Assumes a 40 MHz reference clock and a host-driven serial clock.
`ifndef SMON_PARAMS_SVH
`define SMON_PARAMS_SVH

`define REF_CLK_MHZ       40
`define CS_TIMEOUT_US     100
`define CS_TIMEOUT_CYCLES (`CS_TIMEOUT_US * `REF_CLK_MHZ)
`define BYTE_BITS         8
`define SA_READ_BYTES     2
`define SA_WRITE_BYTES    3
`define DC_CMD_BYTES      3
`define SA_RW_POS         7
`define MEAS_PAGE         3'h3
`define MEAS_ADDR         6'h08
`define PAGE_FIRST        3'h1
`define PAGE_LAST         3'h4
`define RESP_UNKNOWN      16'h0000
`define TX_IDLE_BYTE      8'h00
`define STRAP_WAIT        2'h3

`endif

// ===== design/smon_pkg.sv
// Types shared by the stack monitor serial port and its users.
// Field layouts follow transmission order, first bit in the top bit.
package smon_pkg;

    typedef struct packed {
        logic        rw;
        logic [2:0]  page;
        logic [5:0]  addr;
        logic [13:0] data;
    } sa_cmd_t;

    typedef struct packed {
        logic [3:0] dev;
        logic       rw;
        logic [2:0] page;
        logic [5:0] addr;
        logic [5:0] data;
        logic [3:0] crc;
    } dc_cmd_t;

    typedef struct packed {
        logic        hit;
        logic [15:0] data;
    } rd_rsp_t;

    typedef enum logic [1:0] {
        HD_IDLE,
        HD_READY,
        HD_SEND
    } hd_state_t;

endpackage : smon_pkg

// ===== testbench/smon_spi_port_chk.sv
// Assertion checker for the stack monitor host serial port.
// Sees only the port's pins; every check runs on ref_clk.
`timescale 1ns/1ps
`default_nettype none

module smon_spi_port_chk (
    input wire logic              ref_clk,
    input wire logic              rstn,
    input wire logic              sclk,
    input wire logic              cs_n,
    input wire logic              din,
    input wire logic              daisy_cfg,
    input wire logic              rd_done,
    input wire smon_pkg::rd_rsp_t rd_rsp,
    input wire logic              rsp_valid,
    input wire logic [7:0]        rsp_byte,
    input wire logic              dout,
    input wire logic              dout_oe,
    input wire logic              data_ready_n,
    input wire logic              cmd_valid,
    input wire smon_pkg::sa_cmd_t cmd,
    input wire logic              dc_valid,
    input wire smon_pkg::dc_cmd_t dc_cmd,
    input wire logic              rsp_ready
);
    import smon_pkg::*;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Six samples cover the two-flop sync plus the output register
    sequence s_cs_idle;
        cs_n[*6];
    endsequence
    sequence s_cs_busy;
        (!cs_n && !daisy_cfg)[*6];
    endsequence
    sequence s_take;
        rsp_valid && rsp_ready && cs_n;
    endsequence
    sequence s_tx_end;
        $rose(cs_n) && !data_ready_n;
    endsequence

    a_oe_released: assert property (s_cs_idle |-> !dout_oe)
        else $error("dout driven with chip select high");
    a_oe_driven: assert property (s_cs_busy |-> dout_oe)
        else $error("dout not driven in a frame");
    a_rdy_take: assert property (s_take |-> ##[1:2] !data_ready_n)
        else $error("data ready late after byte taken");
    a_take_hold: assert property (s_take |=> !rsp_ready)
        else $error("second byte accepted while one is held");
    a_rdy_release: assert property (s_tx_end |-> ##[1:5] data_ready_n)
        else $error("data ready not released");
    a_rx_ignored: assert property (s_tx_end |-> !dc_valid[*6])
        else $error("command taken from a transmit frame");
    a_no_rdy_cs: assert property (
        $fell(data_ready_n) |-> cs_n && $past(cs_n))
        else $error("data ready asserted under chip select");
    a_cmd_framed: assert property (
        (cmd_valid || dc_valid) |->
            cs_n && $past(cs_n, 2) ##1 !(cmd_valid || dc_valid))
        else $error("command outside frame gap or too long");
    a_sa_quiet: assert property (
        !daisy_cfg |-> data_ready_n && !dc_valid)
        else $error("daisy output in stand-alone mode");
    a_dc_quiet: assert property (daisy_cfg |-> !cmd_valid)
        else $error("stand-alone command in daisy mode");
endmodule : smon_spi_port_chk

bind smon_spi_port smon_spi_port_chk chk_u (
    .ref_clk(ref_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .din(din), .daisy_cfg(daisy_cfg), .rd_done(rd_done),
    .rd_rsp(rd_rsp), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
    .dout(dout), .dout_oe(dout_oe), .data_ready_n(data_ready_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .dc_valid(dc_valid),
    .dc_cmd(dc_cmd), .rsp_ready(rsp_ready)
);

`default_nettype wire

// ===== testbench/smon_host_model.sv
// Host serial master model: one n-bit frame per xfer call.
// Assumes mode 0; sclk stands still between frames.
`timescale 1ns/1ps
`default_nettype none

module smon_host_model (
    output var logic  sclk,
    output var logic  cs_n,
    output var logic  din,
    input  wire logic dout,
    input  wire logic dout_oe
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // Short frames (n < 8) are used on purpose to abort a command or cut a transmit frame
    task automatic xfer(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
        rx = 8'h00;
        #7 cs_n = 1'b0;
        #120;
        for (int i = 7; i > 7 - n; i--) begin
            din = tx[i];
            // Runs faster than a real host may, to keep the run short
            #40 sclk = 1'b1;
            // Released line reads as the inverse, so a late enable shows
            rx[i] = dout_oe ? dout : ~dout;
            #40 sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        din = ~din;
        #200;
    endtask : xfer
endmodule : smon_host_model

`default_nettype wire

// ===== testbench/test_stack_monitor_host_spi_port.sv
// Self-checking bench for the stack monitor host serial port.
// Bench drives ref-side inputs; the host model drives the link.
`timescale 1ns/1ps
`default_nettype none

module test_stack_monitor_host_spi_port;
    import smon_pkg::*;

    logic       ref_clk   = 1'b0;
    logic       rstn      = 1'b0;
    logic       daisy_cfg = 1'b0;
    logic       rd_done   = 1'b0;
    rd_rsp_t    rd_rsp    = '0;
    logic       rsp_valid = 1'b0;
    logic [7:0] rsp_byte  = 8'h00;
    logic       sclk;
    logic       cs_n;
    logic       din;
    logic       dout;
    logic       dout_oe;
    logic       data_ready_n;
    logic       cmd_valid;
    sa_cmd_t    cmd;
    logic       dc_valid;
    dc_cmd_t    dc_cmd;
    logic       rsp_ready;
    int         error_cnt = 0;
    int         cmp_count = 0;
    sa_cmd_t    exp_cmd[$];
    dc_cmd_t    exp_dc[$];

    always #12.5 ref_clk = ~ref_clk;

    smon_spi_port dut_u (
        .ref_clk(ref_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
        .din(din), .daisy_cfg(daisy_cfg), .rd_done(rd_done),
        .rd_rsp(rd_rsp), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
        .dout(dout), .dout_oe(dout_oe), .data_ready_n(data_ready_n),
        .cmd_valid(cmd_valid), .cmd(cmd), .dc_valid(dc_valid),
        .dc_cmd(dc_cmd), .rsp_ready(rsp_ready)
    );
    smon_host_model host_u (
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe)
    );

    task automatic note(input logic bad, input logic [23:0] g, e);
        cmp_count++;
        if (bad) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : note
    task automatic chk_cmd(input sa_cmd_t g, e);
        note(g !== e, g, e);
    endtask : chk_cmd
    task automatic chk_dc(input dc_cmd_t g, e);
        note(g !== e, g, e);
    endtask : chk_dc
    task automatic chk_byte(input logic [7:0] g, e);
        note(g !== e, {16'h0000, g}, {16'h0000, e});
    endtask : chk_byte

    // Unexpected pulses meet an unknown note and so always mismatch
    always @(posedge ref_clk) begin
        if (cmd_valid === 1'b1)
            chk_cmd(cmd, exp_cmd.size() > 0 ? exp_cmd.pop_front() : 'x);
        if (dc_valid === 1'b1)
            chk_dc(dc_cmd, exp_dc.size() > 0 ? exp_dc.pop_front() : 'x);
    end

    function automatic logic cond(input int k);
        case (k)
            0: return rsp_valid && rsp_ready === 1'b1;
            1: return data_ready_n === 1'b0;
            default: return data_ready_n === 1'b1;
        endcase
    endfunction : cond

    task automatic wait_for(input int k);
        int n;
        n = 0;
        while (!cond(k) && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 300) note(1'b1, 24'(k), 24'hffffff);
    endtask : wait_for

    task automatic send(input logic [23:0] v, input int nb,
                        output logic [23:0] rx);
        for (int b = 0; b < nb; b++)
            host_u.xfer(v[23 - 8*b -: 8], 8, rx[23 - 8*b -: 8]);
    endtask : send

    task automatic answer(input logic hit, input logic [15:0] d);
        @(posedge ref_clk);
        rd_done <= 1'b1;
        rd_rsp  <= '{hit, d};
        @(posedge ref_clk);
        rd_done <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : answer

    // Fill bits ride in the top of the data field on the wire
    task automatic sa_rd(input logic [2:0] pg, input logic [5:0] ad,
                         input logic [5:0] fill, output logic [15:0] rx);
        logic [23:0] r;
        logic        meas;
        meas = (pg == 3'h3) && (ad == 6'h08);
        if (pg inside {[3'h1:3'h4]})
            exp_cmd.push_back('{1'b0, pg, ad, meas ? {8'h00, fill} : 14'h0});
        send({1'b0, pg, ad, fill, 8'h00}, 2, r);
        rx = r[23:8];
    endtask : sa_rd

    task automatic sa_wr(input logic [2:0] pg, output logic [15:0] rx);
        logic [23:0] r;
        sa_cmd_t     c;
        c = '{1'b1, pg, 6'($urandom()), 14'($urandom())};
        if (pg inside {[3'h1:3'h4]}) exp_cmd.push_back(c);
        send(c, 3, r);
        rx = r[23:8];
    endtask : sa_wr

    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask : end_test

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        give_verdict();
    end

    initial begin
        logic [15:0] rx;
        logic [15:0] d;
        logic [7:0]  b;
        logic [23:0] r;
        dc_cmd_t     dc;
        void'($urandom(32'h5f450586));
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        sa_rd(3'h1, 6'($urandom()), 6'h00, rx);
        d = 16'($urandom());
        answer(1'b1, d);
        sa_wr(3'h2, rx);
        chk_byte(rx[15:8], d[15:8]);
        chk_byte(rx[7:0], d[7:0]);
        end_test("read then write");
        sa_rd(3'h3, 6'h08, 6'($urandom()), rx);
        answer(1'b0, 16'($urandom()));
        sa_rd(3'h0, 6'($urandom()), 6'h00, rx);
        chk_byte(rx[15:8], 8'h00);
        sa_rd(3'h4, 6'($urandom()), 6'h00, rx);
        chk_byte(rx[7:0], 8'h00);
        d = 16'($urandom());
        answer(1'b1, d);
        for (int p = 0; p < 8; p++) begin
            sa_wr(3'(p), rx);
            if (p == 0) chk_byte(rx[15:8], d[15:8]);
        end
        end_test("pages");
        host_u.xfer(8'h15, 8, b);
        host_u.xfer(8'hff, 5, b);
        sa_wr(3'h1, rx);
        host_u.xfer(8'h80 | 8'($urandom()), 8, b);
        repeat (4100) @(posedge ref_clk);
        sa_rd(3'h2, 6'($urandom()), 6'h00, rx);
        end_test("abort and timeout");
        @(posedge ref_clk);
        rstn      <= 1'b0;
        daisy_cfg <= 1'b1;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        for (int k = 0; k < 5; k++) begin
            if (k == 0 || k == 4) begin
                dc = dc_cmd_t'($urandom());
                exp_dc.push_back(dc);
                send(dc, 3, r);
            end
            if (k > 0 && k < 4) begin
                @(posedge ref_clk);
                b = 8'($urandom());
                rsp_byte  <= b;
                rsp_valid <= 1'b1;
                wait_for(0);
                rsp_valid <= 1'b0;
                wait_for(1);
                // A cut transmit frame must leave the byte held for a retry
                if (k == 2) begin
                    host_u.xfer(8'($urandom()), 3, rx[15:8]);
                    wait_for(1);
                end
                host_u.xfer(8'($urandom()), 8, rx[7:0]);
                chk_byte(rx[7:0], b);
                wait_for(2);
            end
        end
        chk_byte(8'(exp_cmd.size() + exp_dc.size()), 8'h00);
        end_test("daisy");
        give_verdict();
    end
endmodule : test_stack_monitor_host_spi_port

`default_nettype wire
